// [hdl/odslc_top.sv]
`timescale 1ns/1ps
module odslc_top #(
    parameter int RES = odslc_pkg::DAC_RES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sync_n_in,
    input wire logic sclk_in,
    input wire logic din_in,
    input wire logic load_strobe_n_in,
    output logic buf_power_out,
    output logic [odslc_pkg::FRAME_BITS-1:0] frame_word_out,
    output logic frame_valid_out,
    output logic [odslc_pkg::CH_NUM*RES-1:0] dac_codes_out,
    output logic [odslc_pkg::CH_NUM-1:0] pending_out,
    output odslc_pkg::odslc_ref_mode_t ref_input_lower_quad_out,
    output odslc_pkg::odslc_ref_mode_t ref_input_upper_quad_out
);
    localparam int NCH = odslc_pkg::CH_NUM;
    localparam int FB = odslc_pkg::FRAME_BITS;
    localparam int ADDR_W = odslc_pkg::ADDR_MSB - odslc_pkg::ADDR_LSB + 1;


    generate
        if (RES < 1 || RES > odslc_pkg::DATA_MSB + 1) begin : g_bad_res
            $error("RES must lie between 1 and 12");
        end
        // Counter must end a frame exactly, without wrapping
        if (odslc_pkg::CNT_LAST != FB) begin : g_bad_last
            $error("Frame end count must equal the frame length");
        end
        if (FB >= (1 << odslc_pkg::CNT_W)) begin : g_bad_cnt_w
            $error("Bit counter too narrow for one frame");
        end
        // Address field must name every channel, code bits below it
        if ((1 << ADDR_W) != NCH) begin : g_bad_addr
            $error("Address field does not match channel count");
        end
        if (odslc_pkg::DATA_MSB >= odslc_pkg::ADDR_LSB) begin : g_bad_data
            $error("Code field overlaps the address field");
        end
    endgenerate

    // Whole block state; s1 and s2 are the two synchroniser stages
    typedef struct packed {
        odslc_pkg::odslc_pins_t s1;
        odslc_pkg::odslc_pins_t s2;
        logic sclk_prev;
        logic sync_prev_n;
        odslc_pkg::odslc_frame_st_t st;
        logic [odslc_pkg::CNT_W-1:0] cnt;
        logic [FB-1:0] shift;
        logic [FB-1:0] word;
        logic word_vld;
        logic [NCH-1:0][RES-1:0] in_reg;
        logic [NCH-1:0][RES-1:0] dac_reg;
        logic [NCH-1:0] pend;
        logic buf_lo;
        logic buf_hi;
        logic vdd_lo;
        logic vdd_hi;
    } odslc_state_t;

    odslc_state_t st_r;
    odslc_state_t st_nxt;

    // Raw pins; only the second synchroniser stage feeds logic
    odslc_pkg::odslc_pins_t pins;
    assign pins.sync_n = sync_n_in;
    assign pins.sclk = sclk_in;
    assign pins.din = din_in;
    assign pins.load_n = load_strobe_n_in;

    function automatic odslc_pkg::odslc_ref_mode_t ref_mode(
        input logic buf_en,
        input logic vdd_sel
    );
        odslc_pkg::odslc_ref_mode_t m;
        // Supply select overrides the buffer bit
        if (vdd_sel) begin
            m = odslc_pkg::REF_SUPPLY;
        end else if (buf_en) begin
            m = odslc_pkg::REF_BUF;
        end else begin
            m = odslc_pkg::REF_UNBUF;
        end
        return m;
    endfunction

    always_comb begin
        logic fall;
        logic sync_fall;
        logic sync_rise;
        logic [FB-1:0] w;
        logic [2:0] ch;
        logic last_bit;

        fall = 1'b0;
        sync_fall = 1'b0;
        sync_rise = 1'b0;
        w = '0;
        ch = 3'h0;
        last_bit = 1'b0;

        st_nxt = st_r;
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.sclk_prev = st_r.s2.sclk;
        st_nxt.sync_prev_n = st_r.s2.sync_n;
        st_nxt.word_vld = 1'b0;
        // Edges are seen three core cycles late and each sclk level
        // must last three core cycles, so the usable serial rate is
        // well below what the host may run
        fall = st_r.sclk_prev & ~st_r.s2.sclk;
        sync_fall = st_r.sync_prev_n & ~st_r.s2.sync_n;
        sync_rise = ~st_r.sync_prev_n & st_r.s2.sync_n;
        last_bit = (st_r.cnt + 5'h01 == odslc_pkg::CNT_LAST);

        // Load strobe low moves pending codes; held low it tracks writes
        if (!st_r.s2.load_n) begin
            for (int i = 0; i < NCH; i++) begin
                if (st_r.pend[i]) begin
                    st_nxt.dac_reg[i] = st_r.in_reg[i];
                end
            end
            st_nxt.pend = '0;
        end

        case (st_r.st)
            odslc_pkg::FR_IDLE: begin
                if (sync_fall) begin
                    st_nxt.st = odslc_pkg::FR_SHIFT;
                    // Fresh count each frame; an abort leaves no residue
                    st_nxt.cnt = '0;
                end
            end

            odslc_pkg::FR_SHIFT: begin
                // Abort beats a fall seen in the same cycle
                if (sync_rise) begin
                    // Partial frame dropped; registers untouched
                    st_nxt.st = odslc_pkg::FR_IDLE;
                end else if (fall) begin
                    w = {st_r.shift[FB-2:0], st_r.s2.din};
                    st_nxt.shift = w;
                    st_nxt.cnt = st_r.cnt + 5'h01;
                    if (last_bit) begin
                        st_nxt.st = odslc_pkg::FR_DONE;
                        st_nxt.word = w;
                        st_nxt.word_vld = 1'b1;
                        // Control frame sets both quads' reference modes
                        if (w[odslc_pkg::CTRL_BIT]) begin
                            st_nxt.buf_lo = w[odslc_pkg::BUF_LO_BIT];
                            st_nxt.buf_hi = w[odslc_pkg::BUF_HI_BIT];
                            st_nxt.vdd_lo = w[odslc_pkg::VDD_LO_BIT];
                            st_nxt.vdd_hi = w[odslc_pkg::VDD_HI_BIT];
                        end else begin
                            ch = w[odslc_pkg::ADDR_MSB:odslc_pkg::ADDR_LSB];
                            // Left-justified straight binary code
                            st_nxt.in_reg[ch] =
                                w[odslc_pkg::DATA_MSB -: RES];
                            // Set wins over a same-cycle load clear
                            st_nxt.pend[ch] = 1'b1;
                        end
                    end
                end
            end

            odslc_pkg::FR_DONE: begin
                // Further clocks ignored until sync rises
                if (sync_rise) begin
                    st_nxt.st = odslc_pkg::FR_IDLE;
                end
            end

            default: begin
                st_nxt.st = odslc_pkg::FR_IDLE;
            end
        endcase
    end

    // Synchronous reset; pin stages start at their idle levels
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st_r.s1 <= '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0,
                         load_n: 1'b1};
            st_r.s2 <= '{sync_n: 1'b1, sclk: 1'b1, din: 1'b0,
                         load_n: 1'b1};
            // Idle-high history, so release shows no false edge
            st_r.sclk_prev <= 1'b1;
            st_r.sync_prev_n <= 1'b1;
            st_r.st <= odslc_pkg::FR_IDLE;
            st_r.cnt <= '0;
            st_r.shift <= '0;
            st_r.word <= '0;
            st_r.word_vld <= 1'b0;

            // Power-on codes are zero
            st_r.in_reg <= '0;
            st_r.dac_reg <= '0;
            st_r.pend <= '0;
            st_r.buf_lo <= 1'b0;
            st_r.buf_hi <= 1'b0;
            st_r.vdd_lo <= 1'b0;
            st_r.vdd_hi <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Buffers live only while a frame shifts; a finished or aborted
    // frame leaves them off until the next sync fall
    assign buf_power_out = (st_r.st == odslc_pkg::FR_SHIFT);
    assign frame_word_out = st_r.word;
    assign frame_valid_out = st_r.word_vld;
    assign dac_codes_out = st_r.dac_reg;
    assign pending_out = st_r.pend;
    // One reference setting per quad
    assign ref_input_lower_quad_out =
        ref_mode(st_r.buf_lo, st_r.vdd_lo);
    assign ref_input_upper_quad_out =
        ref_mode(st_r.buf_hi, st_r.vdd_hi);
endmodule

// [inc/odslc_pkg.sv]
// Overview of operation
// - Sync falling powers buffers, arms shift register
// - Capture one bit per falling edge, sixteen
// - Early sync rise aborts, nothing changes
// - Sixteen-bit shift register advances on falls
// - Buffers power down after frame until sync
// - Load strobe copies input into DAC registers
// - One load event updates all pending channels
// - Buffer and supply bits pick reference mode
// - One reference per quad: A-D, E-H
// - Codes are straight unsigned binary
package odslc_pkg;
    localparam int CH_NUM = 8;
    localparam int DAC_RES = 12;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h10;
    // Frame layout
    localparam int CTRL_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 12;
    localparam int DATA_MSB = 11;
    localparam int BUF_HI_BIT = 3;
    localparam int BUF_LO_BIT = 2;
    localparam int VDD_HI_BIT = 1;
    localparam int VDD_LO_BIT = 0;
    // Host timing limit; sampling needs several core cycles per level
    localparam longint CORE_CLK_HZ = 50_000_000;
    localparam longint SCLK_MAX_HZ = 30_000_000;
    localparam longint SCLK_SAMPLED_MAX_HZ = CORE_CLK_HZ / 6;

    typedef enum logic [1:0] {
        REF_UNBUF,
        REF_BUF,
        REF_SUPPLY
    } odslc_ref_mode_t;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_SHIFT,
        FR_DONE
    } odslc_frame_st_t;

    typedef struct packed {
        logic sync_n;
        logic sclk;
        logic din;
        logic load_n;
    } odslc_pins_t;
endpackage

// [verif/odslc_host.sv]
`timescale 1ns/1ps
module odslc_host (
    output logic sync_n,
    output logic sclk,
    output logic din
);
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    // Fewer than 16 falls makes an aborted frame
    task automatic send(input logic [15:0] w, input int nfall);
        sync_n = 1'b0;
        for (int i = 15; i > 15 - nfall; i--) begin
            din = w[i];
            #80 sclk = 1'b0;
            #80 sclk = 1'b1;
        end
        #80 sync_n = 1'b1;
        din = ~din; // Released line must not keep its last bit
        #100;
    endtask
endmodule

// [verif/odslc_top_checker.sv]
`timescale 1ns/1ps
module odslc_top_checker #(
    parameter int RES = odslc_pkg::DAC_RES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic sync_n_in,
    input wire logic sclk_in,
    input wire logic din_in,
    input wire logic load_strobe_n_in,
    input wire logic buf_power_out,
    input wire logic [odslc_pkg::FRAME_BITS-1:0] frame_word_out,
    input wire logic frame_valid_out,
    input wire logic [odslc_pkg::CH_NUM*RES-1:0] dac_codes_out,
    input wire logic [odslc_pkg::CH_NUM-1:0] pending_out,
    input wire odslc_pkg::odslc_ref_mode_t ref_input_lower_quad_out,
    input wire odslc_pkg::odslc_ref_mode_t ref_input_upper_quad_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence load_held;
        !load_strobe_n_in [*3];
    endsequence
    sequence load_off;
        load_strobe_n_in [*3];
    endsequence
    a_sync_power: assert property (
        $fell(sync_n_in) |-> ##[2:4] buf_power_out)
        else $error("buffers not powered after sync fall");
    a_valid_pulse: assert property (
        frame_valid_out |=> !frame_valid_out)
        else $error("frame valid longer than one cycle");
    a_word_hold: assert property (
        !frame_valid_out |-> $stable(frame_word_out))
        else $error("frame word changed without valid");
    a_power_done: assert property (
        frame_valid_out |-> !buf_power_out)
        else $error("buffers powered after frame end");
    a_power_idle: assert property (
        sync_n_in [*5] |-> !buf_power_out)
        else $error("buffers powered while sync high");
    a_pend_set: assert property (
        frame_valid_out && !frame_word_out[15]
        |-> pending_out[frame_word_out[14:12]])
        else $error("pending not set by data frame");
    a_load_clear: assert property (
        load_held ##1 !frame_valid_out |-> pending_out == '0)
        else $error("pending left after load");
    a_codes_hold: assert property (
        load_off |=> $stable(dac_codes_out))
        else $error("dac codes changed without load");
    a_ref_legal: assert property (
        ref_input_lower_quad_out != 2'h3
        && ref_input_upper_quad_out != 2'h3)
        else $error("illegal reference mode");
    a_ref_decode: assert property (
        frame_valid_out && frame_word_out[15] |->
            ref_input_lower_quad_out == (frame_word_out[0] ? 2'h2
                : {1'b0, frame_word_out[2]})
            && ref_input_upper_quad_out == (frame_word_out[1] ? 2'h2
                : {1'b0, frame_word_out[3]}))
        else $error("reference mode not taken from control frame");
endmodule
bind odslc_top odslc_top_checker #(.RES(RES)) chk (.*);

// [verif/test_odslc_top.sv]
`timescale 1ns/1ps
module test_odslc_top;
    localparam int R = odslc_pkg::DAC_RES;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_n = 1'b1;
    logic sync_n, sclk, din, power, valid;
    logic [15:0] word;
    logic [odslc_pkg::CH_NUM*R-1:0] codes;
    logic [7:0] pend;
    odslc_pkg::odslc_ref_mode_t ref_lo, ref_hi;
    int n_mismatch = 0;
    int num_checks = 0;
    always #10 core_clk = ~core_clk;
    odslc_host host (.sync_n(sync_n), .sclk(sclk), .din(din));
    odslc_top uut (.core_clk_in(core_clk), .rst_n_in(rst_n),
        .sync_n_in(sync_n), .sclk_in(sclk), .din_in(din),
        .load_strobe_n_in(load_n), .buf_power_out(power),
        .frame_word_out(word), .frame_valid_out(valid),
        .dac_codes_out(codes), .pending_out(pend),
        .ref_input_lower_quad_out(ref_lo),
        .ref_input_upper_quad_out(ref_hi));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] mode(input logic b, input logic v);
        return v ? odslc_pkg::REF_SUPPLY : b ? odslc_pkg::REF_BUF
            : odslc_pkg::REF_UNBUF;
    endfunction
    task automatic t_load();
        host.send(16'h7fff, 16);
        host.send(16'h0001, 16);
        check(word, 16'h0001);
        check(pend, 8'h81);
        check(codes[7*R +: R], 16'h0);
        @(negedge core_clk) load_n = 1'b0;
        repeat (3) @(negedge core_clk);
        load_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check(codes[7*R +: R], 12'hfff);
        check(codes[0 +: R], 12'h001);
        check(pend, 8'h00);
        $display("t_load done");
    endtask
    task automatic t_abort();
        host.send(16'h3123, 15);
        host.send(16'h3123, 1);
        check(word, 16'h0001);
        check(pend, 8'h00);
        check(power, 1'b0);
        $display("t_abort done");
    endtask
    task automatic t_ref();
        logic [15:0] w [4] = '{16'h8000, 16'h8008, 16'h8006, 16'h800f};
        foreach (w[i]) begin
            host.send(w[i], 16);
            check(ref_lo, mode(w[i][2], w[i][0]));
            check(ref_hi, mode(w[i][3], w[i][1]));
        end
        $display("t_ref done");
    endtask
    task automatic t_track();
        @(negedge core_clk) load_n = 1'b0;
        repeat (3) @(negedge core_clk);
        host.send(16'h25a5, 16);
        check(codes[2*R +: R], 12'h5a5);
        check(pend, 8'h00);
        load_n = 1'b1;
        $display("t_track done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check({power, pend, ref_lo, ref_hi}, 16'h0);
        t_load();
        t_abort();
        t_ref();
        t_track();
        give_verdict();
    end
    initial begin
        #1000000 n_mismatch++;
        give_verdict();
    end
endmodule
